// ### inc/mac_ctl_pkg.sv
/*
  Constants for the MAC speed and duplex control block: register offsets,
  field positions, encodings and reset values.
  Assumes a 32-bit classic Wishbone register bus with word addressing in bytes.
*/
package mac_ctl_pkg;
  localparam logic [7:0] MAC_CONTROL_OFFS     = 8'h00;
  localparam logic [7:0] NV_IMAGE_OFFS        = 8'h04;
  localparam logic [7:0] LINK_STATUS_OFFS     = 8'h08;

  localparam int RST_BIT          = 0;
  localparam int SPEED_LSB        = 1;
  localparam int DUPLEX_BIT       = 3;
  localparam int AUTO_SPEED_BIT   = 11;
  localparam int AUTO_DUPLEX_BIT  = 12;
  localparam int RST_PROTECT_BIT  = 13;
  localparam int RECEIVER_ON_BIT  = 14;
  localparam int TRANSMIT_ON_BIT  = 15;

  localparam int FULL_DUPLEX_BIT  = 0;
  localparam int HALF_ALLOWED_BIT = 1;
  localparam int IN_RESET_BIT     = 2;

  typedef enum logic [1:0] {
    SPEED_10   = 2'h0,
    SPEED_100  = 2'h1,
    SPEED_1000 = 2'h2,
    SPEED_RSVD = 2'h3
  } speed_t;

  localparam logic [1:0] SPEED_RESET       = 2'h0;
  localparam logic       DUPLEX_RESET      = 1'h0;
  localparam logic       AUTO_DUPLEX_RESET = 1'h1;
  localparam logic       AUTO_SPEED_RESET  = 1'h0;
  localparam logic [3:0] MAC_RESET_CYCLES  = 4'h4;
endpackage

// ### inc/nv_image_if.sv
/*
  Carrier for the configuration image between the top and its loader.
  Assumes one clock shared by both ends.
*/
`timescale 1ns/10ps
`default_nettype none
interface nv_image_if;
  logic       valid;
  logic       auto_duplex;
  logic       auto_speed;
  logic       duplex;
  logic [1:0] speed;
  modport loader (output valid, auto_duplex, auto_speed, duplex, speed);
  modport user   (input  valid, auto_duplex, auto_speed, duplex, speed);
endinterface
`default_nettype wire

// ### hdl/nv_image_loader.sv
/*
  Holds the configuration image last loaded from EEPROM, or from one-time memory while no EEPROM image has come.
  Assumes the source strobes arrive synchronous to clk_i from the fetch logic.
*/
`timescale 1ns/10ps
`default_nettype none
module nv_image_loader (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       eeprom_load_i,
  input  wire logic       otp_load_i,
  input  wire logic [1:0] cfg0_i,
  input  wire logic [2:0] cfg2_i,
  nv_image_if.loader      img
);
  // Power-up values: a bus reset must not wipe the image, so rst_i is not used here
  logic       eeprom_seen_reg = 1'b0;
  logic       eeprom_seen_next;
  logic       loaded_reg      = 1'b0;
  logic       loaded_next;
  logic [4:0] image_reg       = {mac_ctl_pkg::AUTO_DUPLEX_RESET, mac_ctl_pkg::AUTO_SPEED_RESET,
                                 mac_ctl_pkg::DUPLEX_RESET, mac_ctl_pkg::SPEED_RESET};
  logic [4:0] image_next;

  always_comb begin
    eeprom_seen_next = eeprom_seen_reg | eeprom_load_i;
    loaded_next      = loaded_reg | eeprom_load_i | otp_load_i;
    image_next       = image_reg;
    // EEPROM wins over one-time memory, even when both come in one cycle
    if (eeprom_load_i) begin
      image_next = {cfg0_i, cfg2_i};
    end else if (otp_load_i && !eeprom_seen_reg) begin
      image_next = {cfg0_i, cfg2_i};
    end
  end

  // The image survives a bus reset: only the power-up value is a constant
  always_ff @(posedge clk_i) begin
    eeprom_seen_reg <= eeprom_seen_next;
    loaded_reg      <= loaded_next;
    image_reg       <= image_next;
  end

  // Until any image arrives, the fallback defaults are reported
  assign img.valid       = loaded_reg;
  assign img.auto_duplex = image_reg[4];
  assign img.auto_speed  = image_reg[3];
  assign img.duplex      = image_reg[2];
  assign img.speed       = image_reg[1:0];
endmodule
`default_nettype wire

// ### hdl/mac_speed_duplex_control.sv
/*
  MAC operating configuration: duplex, speed, detection enables and the
  self-clearing MAC reset, reached over classic Wishbone.
  Assumes detected link state is synchronous to clk_i and that rst_i is the
  USB reset or soft lite reset.
*/
// Added by the designer: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module mac_speed_duplex_control (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic             err_o,
  input  wire logic        det_full_duplex_i,
  input  wire logic [1:0]  det_speed_i,
  input  wire logic        eeprom_load_i,
  input  wire logic        otp_load_i,
  input  wire logic [1:0]  cfg0_i,
  input  wire logic [2:0]  cfg2_i,
  output logic             mac_reset_o,
  output logic             full_duplex_o,
  output logic             gmii_sel_o,
  output logic [1:0]       speed_o,
  output logic             receiver_on_o,
  output logic             transmitter_on_o
);
  nv_image_if img ();

  nv_image_loader u_loader (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .eeprom_load_i (eeprom_load_i),
    .otp_load_i    (otp_load_i),
    .cfg0_i        (cfg0_i),
    .cfg2_i        (cfg2_i),
    .img           (img)
  );

  logic       duplex_reg,  duplex_next;
  logic [1:0] speed_reg,   speed_next;
  logic       auto_dpx_reg, auto_dpx_next;
  logic       auto_spd_reg, auto_spd_next;
  logic       protect_reg = 1'b0;
  logic       protect_next;
  logic       rst_d_reg, rst_d_next;
  logic       rx_on_reg,   rx_on_next;
  logic       tx_on_reg,   tx_on_next;
  logic [3:0] rst_cnt_reg, rst_cnt_next;
  logic       ack_reg,     ack_next;
  logic       err_reg,     err_next;
  logic [31:0] rdat_reg,   rdat_next;
  logic       eff_dpx_reg, eff_dpx_next;
  logic [1:0] eff_spd_reg, eff_spd_next;
  logic       det_dpx_reg, det_dpx_next;
  logic [1:0] det_spd_reg, det_spd_next;

  logic        req;
  logic        wr_ctl;
  logic [31:0] ctl_view;
  logic [1:0]  eff_spd;
  logic        eff_dpx;

  assign req    = cyc_i & stb_i & ~ack_reg & ~err_reg;
  assign wr_ctl = req & we_i & sel_i[0] & (adr_i == mac_ctl_pkg::MAC_CONTROL_OFFS);

  // Detected values are read back while detection owns the field
  always_comb begin
    eff_spd = auto_spd_reg ? det_spd_reg : speed_reg;
    eff_dpx = auto_dpx_reg ? det_dpx_reg : duplex_reg;
    ctl_view = 32'h0000_0000;
    ctl_view[mac_ctl_pkg::RST_BIT]               = (rst_cnt_reg != 4'h0);
    ctl_view[mac_ctl_pkg::SPEED_LSB +: 2]        = eff_spd;
    ctl_view[mac_ctl_pkg::DUPLEX_BIT]            = eff_dpx;
    ctl_view[mac_ctl_pkg::AUTO_SPEED_BIT]        = auto_spd_reg;
    ctl_view[mac_ctl_pkg::AUTO_DUPLEX_BIT]       = auto_dpx_reg;
    ctl_view[mac_ctl_pkg::RST_PROTECT_BIT]       = protect_reg;
    ctl_view[mac_ctl_pkg::RECEIVER_ON_BIT]       = rx_on_reg;
    ctl_view[mac_ctl_pkg::TRANSMIT_ON_BIT]       = tx_on_reg;
  end

  // Configuration group
  always_comb begin
    duplex_next   = duplex_reg;
    speed_next    = speed_reg;
    auto_dpx_next = auto_dpx_reg;
    auto_spd_next = auto_spd_reg;
    protect_next  = protect_reg;
    rx_on_next    = rx_on_reg;
    tx_on_next    = tx_on_reg;
    det_dpx_next  = det_full_duplex_i;
    det_spd_next  = det_speed_i;
    rst_d_next    = rst_i;
    // Protection spans a whole reset, however long, and ends at its release
    if (rst_d_reg && !rst_i) begin
      protect_next = 1'b0;
    end
    if (rst_i) begin
      auto_dpx_next = img.auto_duplex;
      auto_spd_next = img.auto_speed;
      rx_on_next    = 1'b0;
      tx_on_next    = 1'b0;
      if (!protect_reg) begin
        duplex_next = img.duplex;
        speed_next  = img.speed;
      end
      // A protected field keeps its value across this reset
    end else if (wr_ctl) begin
      if (!auto_dpx_reg) begin
        duplex_next = dat_i[mac_ctl_pkg::DUPLEX_BIT];
      end
      // Reserved code 11 is refused and the old speed stays
      if (!auto_spd_reg && dat_i[mac_ctl_pkg::SPEED_LSB +: 2] != mac_ctl_pkg::SPEED_RSVD) begin
        speed_next = dat_i[mac_ctl_pkg::SPEED_LSB +: 2];
      end
    end
    if (!rst_i && req && we_i && adr_i == mac_ctl_pkg::MAC_CONTROL_OFFS && sel_i[1]) begin
      auto_spd_next = dat_i[mac_ctl_pkg::AUTO_SPEED_BIT];
      auto_dpx_next = dat_i[mac_ctl_pkg::AUTO_DUPLEX_BIT];
      protect_next  = dat_i[mac_ctl_pkg::RST_PROTECT_BIT];
      rx_on_next    = dat_i[mac_ctl_pkg::RECEIVER_ON_BIT];
      tx_on_next    = dat_i[mac_ctl_pkg::TRANSMIT_ON_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    duplex_reg   <= duplex_next;
    speed_reg    <= speed_next;
    auto_dpx_reg <= auto_dpx_next;
    auto_spd_reg <= auto_spd_next;
    protect_reg  <= protect_next;
    rst_d_reg    <= rst_d_next;
    rx_on_reg    <= rx_on_next;
    tx_on_reg    <= tx_on_next;
    det_dpx_reg  <= det_dpx_next;
    det_spd_reg  <= det_spd_next;
  end

  // Self-clearing MAC reset: held for a few cycles so the MAC sees it
  always_comb begin
    rst_cnt_next = rst_cnt_reg;
    if (rst_i) begin
      rst_cnt_next = 4'h0;
    end else if (wr_ctl && dat_i[mac_ctl_pkg::RST_BIT]) begin
      rst_cnt_next = mac_ctl_pkg::MAC_RESET_CYCLES;
    end else if (rst_cnt_reg != 4'h0) begin
      rst_cnt_next = rst_cnt_reg - 4'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    rst_cnt_reg <= rst_cnt_next;
  end

  // Operating outputs; half duplex is never used at gigabit
  always_comb begin
    eff_spd_next = eff_spd;
    eff_dpx_next = eff_dpx | (eff_spd == mac_ctl_pkg::SPEED_1000);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      eff_spd_reg <= mac_ctl_pkg::SPEED_RESET;
      eff_dpx_reg <= mac_ctl_pkg::DUPLEX_RESET;
    end else begin
      eff_spd_reg <= eff_spd_next;
      eff_dpx_reg <= eff_dpx_next;
    end
  end

  // Wishbone slave: one registered answer per request, a cycle after it, err on unmapped words
  always_comb begin
    ack_next  = 1'b0;
    err_next  = 1'b0;
    rdat_next = rdat_reg;
    if (!rst_i && req) begin
      unique case (adr_i)
        mac_ctl_pkg::MAC_CONTROL_OFFS: begin
          ack_next  = 1'b1;
          rdat_next = ctl_view;
        end
        mac_ctl_pkg::NV_IMAGE_OFFS: begin
          ack_next  = 1'b1;
          rdat_next = {27'h0, img.auto_duplex, img.auto_speed, img.duplex, img.speed};
        end
        mac_ctl_pkg::LINK_STATUS_OFFS: begin
          ack_next  = 1'b1;
          rdat_next = {29'h0, (rst_cnt_reg != 4'h0), (eff_spd_reg != mac_ctl_pkg::SPEED_1000),
                       eff_dpx_reg};
        end
        default: begin
          err_next  = 1'b1;
          rdat_next = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg  <= 1'b0;
      err_reg  <= 1'b0;
      rdat_reg <= 32'h0000_0000;
    end else begin
      ack_reg  <= ack_next;
      err_reg  <= err_next;
      rdat_reg <= rdat_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mac_reset_o      <= 1'b0;
      full_duplex_o    <= 1'b0;
      gmii_sel_o       <= 1'b0;
      speed_o          <= 2'h0;
      receiver_on_o    <= 1'b0;
      transmitter_on_o <= 1'b0;
    end else begin
      mac_reset_o      <= (rst_cnt_next != 4'h0);
      full_duplex_o    <= eff_dpx_next;
      gmii_sel_o       <= (eff_spd_next == mac_ctl_pkg::SPEED_1000);
      speed_o          <= eff_spd_next;
      receiver_on_o    <= rx_on_next;
      transmitter_on_o <= tx_on_next;
    end
  end

  assign dat_o = rdat_reg;
  assign ack_o = ack_reg;
  assign err_o = err_reg;

  duplex_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_ctl && !auto_dpx_reg |=> duplex_reg == $past(dat_i[3]))
    else $error("duplex bit not written");
  duplex_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    auto_dpx_reg && $past(auto_dpx_reg) && !$past(rst_i) |-> $stable(duplex_reg))
    else $error("duplex changed under auto");
  gig_full_a: assert property (@(posedge clk_i) disable iff (rst_i)
    eff_spd_next == mac_ctl_pkg::SPEED_1000 |=> full_duplex_o)
    else $error("half duplex at gigabit");
  speed_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_ctl && !auto_spd_reg && dat_i[2:1] != 2'h3 |=> speed_reg == $past(dat_i[2:1]))
    else $error("speed not written");
  speed_auto_a: assert property (@(posedge clk_i) disable iff (rst_i)
    auto_spd_reg |-> ##1 (ctl_view[2:1] == det_spd_reg || !auto_spd_reg))
    else $error("auto speed not reported");
  gmii_sel_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 gmii_sel_o == (speed_o == 2'h2))
    else $error("interface select mismatch");
  speed_legal_a: assert property (@(posedge clk_i) disable iff (rst_i)
    speed_reg != 2'h3 || $past(rst_i))
    else $error("reserved speed stored");
  mac_reset_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_ctl && dat_i[0] |=> mac_reset_o [*4] ##1 !mac_reset_o)
    else $error("mac reset pulse wrong");
  protect_keep_a: assert property (@(posedge clk_i)
    rst_i && protect_reg |=> $stable(speed_reg) && $stable(duplex_reg))
    else $error("protected field lost");
  reload_auto_a: assert property (@(posedge clk_i)
    rst_i |=> auto_dpx_reg == $past(img.auto_duplex) && auto_spd_reg == $past(img.auto_speed))
    else $error("auto enables not reloaded");
endmodule
`default_nettype wire

// ### testbench/phy_link_model.sv
/*
  Link partner model: reports the detected duplex and speed after a lag.
  Assumes the bench sets the wanted link state and the lag.
*/
`timescale 1ns/10ps
`default_nettype none
module phy_link_model (
  input  wire logic       clk_i,
  input  wire logic       fd_i,
  input  wire logic [1:0] spd_i,
  input  wire logic [3:0] lag_i,
  output logic            fd_o,
  output logic      [1:0] spd_o
);
  logic [3:0] wait_reg = 4'h0;
  logic [2:0] link_reg = 3'h0;
  // Never reports the reserved speed code; the bench only asks for 00, 01 or 10
  assign {fd_o, spd_o} = link_reg;
  // Negotiation takes time, so a new link state shows only after the lag
  always_ff @(posedge clk_i) begin
    if ({fd_i, spd_i} == link_reg) begin
      wait_reg <= 4'h0;
    end else if (wait_reg >= lag_i) begin
      link_reg <= {fd_i, spd_i};
      wait_reg <= 4'h0;
    end else begin
      wait_reg <= wait_reg + 4'h1;
    end
  end
endmodule
`default_nettype wire

// ### testbench/mac_speed_duplex_control_tb_top.sv
/*
  Self-checking bench for the MAC speed and duplex control block.
  Assumes the link partner model and a 50 MHz clock.
*/
`timescale 1ns/10ps
`default_nettype none
module mac_speed_duplex_control_tb_top;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic        eeprom_load_i = 1'b0, otp_load_i = 1'b0, want_fd = 1'b0;
  logic        ack_o, err_o, re, det_fd, mac_reset_o, full_duplex_o, gmii_sel_o;
  logic        receiver_on_o, transmitter_on_o, ad, as, dp, erx, etx;
  logic [1:0]  det_spd, speed_o, sp, want_spd = 2'h0, cfg0_i = 2'h0;
  logic [2:0]  cfg2_i = 3'h0;
  logic [3:0]  sel_i = 4'h0, lag = 4'h0;
  logic [4:0]  img = 5'h10;
  logic [7:0]  adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0, dat_o, rd, seed = 32'hD3FF;
  int          bad_count = 0, tests_run = 0, cycles = 0, n;

  mac_speed_duplex_control mac_speed_duplex_control_inst (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .err_o(err_o), .det_full_duplex_i(det_fd), .det_speed_i(det_spd),
    .eeprom_load_i(eeprom_load_i), .otp_load_i(otp_load_i), .cfg0_i(cfg0_i),
    .cfg2_i(cfg2_i), .mac_reset_o(mac_reset_o), .full_duplex_o(full_duplex_o),
    .gmii_sel_o(gmii_sel_o), .speed_o(speed_o), .receiver_on_o(receiver_on_o),
    .transmitter_on_o(transmitter_on_o));
  phy_link_model phy_link_model_inst (.clk_i(clk_i), .fd_i(want_fd), .spd_i(want_spd),
    .lag_i(lag), .fd_o(det_fd), .spd_o(det_spd));

  initial begin
    forever #10 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      bad_count++;
      results();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction

  task automatic results();
    if (bad_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: register got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic [6:0] got, input logic [6:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: pins got %b expected %b", $time, got, exp);
    end
  endtask

  // Holds the request until ack or err is sampled, then idles one cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= s;
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1 && err_o !== 1'b1);
    rd = dat_o;
    re = err_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wctl(input logic pr, a_d, a_s, r, t, input logic [1:0] s, input logic d);
    wb(1'b1, mac_ctl_pkg::MAC_CONTROL_OFFS, {16'h0, t, r, pr, a_d, a_s, 7'h0, d, s, 1'b0}, 4'hF);
    if (!as && s != 2'h3) sp = s;
    if (!ad) dp = d;
    {ad, as, erx, etx} = {a_d, a_s, r, t};
  endtask

  task automatic verify();
    logic [1:0] es;
    logic       ed;
    es = as ? want_spd : sp;
    ed = ad ? want_fd : dp;
    wb(1'b0, mac_ctl_pkg::MAC_CONTROL_OFFS, 32'h0, 4'hF);
    chk_reg(rd & 32'h0000_F80F, {16'h0, etx, erx, 1'b0, ad, as, 7'h0, ed, es, 1'b0});
    wb(1'b0, mac_ctl_pkg::LINK_STATUS_OFFS, 32'h0, 4'hF);
    chk_reg(rd & 32'h3, {30'h0, es != 2'h2, (es == 2'h2) | ed});
    chk_pin({mac_reset_o, full_duplex_o, gmii_sel_o, speed_o, receiver_on_o, transmitter_on_o},
            {1'b0, (es == 2'h2) | ed, es == 2'h2, es, erx, etx});
  endtask

  task automatic do_reset(input int len, input logic kept);
    rst_i <= 1'b1;
    repeat (len) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    {ad, as, erx, etx} = {img[4:3], 2'h0};
    if (!kept) {dp, sp} = img[2:0];
  endtask

  task automatic load(input logic ee, input logic [1:0] c0, input logic [2:0] c2);
    eeprom_load_i <= ee;
    otp_load_i    <= !ee;
    cfg0_i        <= c0;
    cfg2_i        <= c2;
    @(posedge clk_i);
    eeprom_load_i <= 1'b0;
    otp_load_i    <= 1'b0;
    img = {c0, c2};
  endtask

  initial begin
    do_reset(20, 1'b0);
    verify();
    wctl(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, sp, dp);
    // Reserved speed code comes in the last pair, right after gigabit, so it must leave gigabit in place
    for (int i = 0; i < 8; i++) begin
      wctl(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, i[2:1], i[0]);
      verify();
    end
    wb(1'b1, mac_ctl_pkg::MAC_CONTROL_OFFS, 32'h0000_C002, 4'h1);
    sp = 2'h1;
    dp = 1'b0;
    verify();
    repeat (16) begin
      seed = xs(seed);
      wctl(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, sp, dp);
      wctl(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, seed[1:0], seed[2]);
      wctl(1'b0, 1'b0, 1'b0, seed[3], seed[4], sp, dp);
      verify();
    end
    wctl(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, sp, dp);
    want_spd <= 2'h2;
    lag      <= 4'h9;
    wctl(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, sp, dp);
    repeat (14) @(posedge clk_i);
    verify();
    wctl(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, sp ^ 2'h1, !dp);
    want_fd  <= 1'b1;
    want_spd <= 2'h1;
    repeat (14) @(posedge clk_i);
    verify();
    wctl(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, sp, dp);
    verify();
    n = 0;
    fork
      repeat (12) begin
        @(posedge clk_i);
        n += mac_reset_o;
      end
      begin
        wb(1'b1, mac_ctl_pkg::MAC_CONTROL_OFFS, {16'h0, 12'h0, dp, sp, 1'b1}, 4'hF);
        wb(1'b0, mac_ctl_pkg::MAC_CONTROL_OFFS, 32'h0, 4'hF);
        chk_reg(rd & 32'h1, 32'h1);
      end
    join
    chk_reg(n, 32'(mac_ctl_pkg::MAC_RESET_CYCLES));
    verify();
    wb(1'b1, 8'h0C, 32'h0000_000C, 4'hF);
    chk_reg({31'h0, re}, 32'h1);
    verify();
    load(1'b0, 2'b00, 3'b101);
    do_reset(2, 1'b0);
    verify();
    load(1'b1, 2'b10, 3'b010);
    do_reset(2, 1'b0);
    verify();
    wctl(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, sp, dp);
    wctl(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 2'h1, 1'b1);
    do_reset(2, 1'b1);
    wb(1'b1, mac_ctl_pkg::MAC_CONTROL_OFFS, 32'h0, 4'h2);
    ad = 1'b0;
    verify();
    do_reset(2, 1'b0);
    verify();
    results();
  end
endmodule
`default_nettype wire
